/* File: common/alu_ops_pkg.sv */
// constants, field layout and instruction kinds for the literal and bit-op datapath
package alu_ops_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_FADDR = 8'h0C;
    localparam logic [7:0] OFF_FDATA = 8'h10;
    // status register bit positions
    localparam int STAT_CARRY = 0;
    localparam int STAT_NIBBLE = 1;
    localparam int STAT_ZERO = 2;
    localparam int STAT_SKIP = 3;
    // instruction word fields
    localparam int INSTR_W = 14;
    localparam int FADDR_LSB = 0;
    localparam int FADDR_W = 7;
    localparam int DEST_POS = 7;
    localparam int BIT_LSB = 7;
    localparam int BIT_W = 3;
    localparam int LIT_LSB = 0;
    localparam int LIT_W = 8;
    // opcode patterns
    localparam logic [5:0] OPC_ADD_REG = 6'h07;
    localparam logic [5:0] OPC_AND_REG = 6'h05;
    localparam logic [4:0] OPC_ADD_IMM = 5'h1F;
    localparam logic [5:0] OPC_AND_IMM = 6'h39;
    localparam logic [1:0] OPC_BIT_GROUP = 2'h1;
    localparam logic [1:0] BIT_CLR = 2'h0;
    localparam logic [1:0] BIT_SET = 2'h1;
    localparam logic [1:0] BIT_SKIP_ZERO = 2'h2;
    localparam logic [1:0] BIT_SKIP_ONE = 2'h3;
    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [13:0] INSTR_RST = 14'h0000;
    // file address that maps onto the i/o port
    localparam logic [6:0] PORT_FADDR = 7'h05;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD_IMM,
        OP_ADD_REG,
        OP_AND_IMM,
        OP_AND_REG,
        OP_BIT_CLR,
        OP_BIT_SET,
        OP_SKIP_ONE,
        OP_SKIP_ZERO
    } op_kind_type;
endpackage : alu_ops_pkg

/* File: logic/alu_literal_and_bit_ops.sv */
// datapath for add, and, bit set/clear and bit-test skip, with apb register access
// Overview of operation
// - add_immediate_to_acc: acc plus 8-bit literal into acc, update carry, nibble carry, zero.
// - add_acc_to_register: acc plus file register, flags updated, destination bit picks target.
// - and_immediate_with_acc: acc AND literal into acc, only zero flag changes.
// - and_acc_with_register: acc AND file register, only zero, destination bit picks target.
// - register_bit_clear forces chosen bit to zero, others kept, no flags touched.
// - register_bit_set forces chosen bit to one, others kept, no flags touched.
// - skip_when_bit_one: bit one discards next instruction as no_operation_cycle.
// - skip_when_bit_zero: bit zero discards next instruction as no_operation_cycle.
// - read-modify-write on the port register reads pin levels, not the latch.
`timescale 1ns/1ps
module alu_literal_and_bit_ops
    import alu_ops_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [7:0] port_pins_i,
    output logic [7:0] port_latch_o
);
    if (FILE_DEPTH != 128) begin : g_depth_check
        $error("file depth must match the 7-bit address field");
    end

    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    logic [7:0] file_q [FILE_DEPTH];
    logic [7:0] port_latch_q;
    logic [7:0] acc_q;
    logic carry_q;
    logic nibble_carry_q;
    logic zero_q;
    logic skip_q;
    logic [13:0] instr_q;
    logic [6:0] faddr_q;

    logic apb_done;
    logic apb_wr;
    logic addr_ok;
    logic [13:0] iw;
    logic [6:0] f_addr;
    logic dest_reg;
    logic [2:0] bit_idx;
    logic [7:0] lit;
    op_kind_type kind;
    logic exec;
    logic [7:0] operand;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] result;
    logic [7:0] bit_mask;
    logic [7:0] fdata_rd;
    logic [31:0] rd_data;

    assign apb_done = psel_i && penable_i && pready_q;
    assign apb_wr = apb_done && pwrite_i;
    assign addr_ok = paddr_i == OFF_INSTR || paddr_i == OFF_ACC || paddr_i == OFF_STATUS
        || paddr_i == OFF_FADDR || paddr_i == OFF_FDATA;
    // fixed instruction fields
    assign iw = pwdata_i[INSTR_W-1:0];
    assign f_addr = iw[FADDR_LSB +: FADDR_W];
    assign dest_reg = iw[DEST_POS];
    assign bit_idx = iw[BIT_LSB +: BIT_W];
    assign lit = iw[LIT_LSB +: LIT_W];
    always_comb begin
        kind = OP_NONE;
        if (iw[13:9] == OPC_ADD_IMM) begin
            kind = OP_ADD_IMM;
        end else if (iw[13:8] == OPC_AND_IMM) begin
            kind = OP_AND_IMM;
        end else if (iw[13:8] == OPC_ADD_REG) begin
            kind = OP_ADD_REG;
        end else if (iw[13:8] == OPC_AND_REG) begin
            kind = OP_AND_REG;
        end else if (iw[13:12] == OPC_BIT_GROUP) begin
            case (iw[11:10])
                BIT_CLR: kind = OP_BIT_CLR;
                BIT_SET: kind = OP_BIT_SET;
                BIT_SKIP_ZERO: kind = OP_SKIP_ZERO;
                BIT_SKIP_ONE: kind = OP_SKIP_ONE;
                default: kind = OP_NONE;
            endcase
        end
    end
    // a pending skip turns the next instruction write into a no-op cycle
    assign exec = apb_wr && paddr_i == OFF_INSTR && !skip_q;
    // port reads see the pins, so an externally pulled-low input writes back as zero
    assign operand = (f_addr == PORT_FADDR) ? pin_sync_q : file_q[f_addr];
    assign sum = {1'b0, acc_q} + {1'b0, (kind == OP_ADD_IMM) ? lit : operand};
    assign low_sum = {1'b0, acc_q[3:0]} + {1'b0, (kind == OP_ADD_IMM) ? lit[3:0] : operand[3:0]};
    assign bit_mask = 8'(8'h01 << bit_idx);
    always_comb begin
        case (kind)
            OP_ADD_IMM, OP_ADD_REG: result = sum[7:0];
            OP_AND_IMM: result = acc_q & lit;
            OP_AND_REG: result = acc_q & operand;
            OP_BIT_CLR: result = operand & ~bit_mask;
            OP_BIT_SET: result = operand | bit_mask;
            default: result = operand;
        endcase
    end
    // two-flop synchroniser on the pins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end else begin
            pin_meta_q <= port_pins_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // accumulator
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            acc_q <= ACC_RST;
        end else if (exec && (kind == OP_ADD_IMM || kind == OP_AND_IMM)) begin
            acc_q <= result;
        end else if (exec && (kind == OP_ADD_REG || kind == OP_AND_REG) && !dest_reg) begin
            acc_q <= result;
        end else if (apb_wr && paddr_i == OFF_ACC) begin
            acc_q <= pwdata_i[7:0];
        end
    end

    // status flags; bit ops and skips leave them alone
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            carry_q <= 1'b0;
            nibble_carry_q <= 1'b0;
            zero_q <= 1'b0;
        end else if (exec && (kind == OP_ADD_IMM || kind == OP_ADD_REG)) begin
            carry_q <= sum[8];
            nibble_carry_q <= low_sum[4];
            zero_q <= result == 8'h00;
        end else if (exec && (kind == OP_AND_IMM || kind == OP_AND_REG)) begin
            zero_q <= result == 8'h00;
        end else if (apb_wr && paddr_i == OFF_STATUS) begin
            carry_q <= pwdata_i[STAT_CARRY];
            nibble_carry_q <= pwdata_i[STAT_NIBBLE];
            zero_q <= pwdata_i[STAT_ZERO];
        end
    end

    // file registers and port latch
    logic wr_file;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    always_comb begin
        wr_file = 1'b0;
        wr_addr = f_addr;
        wr_data = result;
        if (exec && ((kind == OP_ADD_REG || kind == OP_AND_REG) && dest_reg)) begin
            wr_file = 1'b1;
        end else if (exec && (kind == OP_BIT_CLR || kind == OP_BIT_SET)) begin
            wr_file = 1'b1;
        end else if (apb_wr && paddr_i == OFF_FDATA) begin
            wr_file = 1'b1;
            wr_addr = faddr_q;
            wr_data = pwdata_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_file && wr_addr != PORT_FADDR) begin
            file_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            port_latch_q <= PORT_RST;
        end else if (wr_file && wr_addr == PORT_FADDR) begin
            port_latch_q <= wr_data;
        end
    end

    // skip pending: set by a true test, consumed by the next instruction write
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            skip_q <= 1'b0;
        end else if (exec && kind == OP_SKIP_ONE) begin
            skip_q <= operand[bit_idx];
        end else if (exec && kind == OP_SKIP_ZERO) begin
            skip_q <= !operand[bit_idx];
        end else if (apb_wr && paddr_i == OFF_INSTR) begin
            skip_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            instr_q <= INSTR_RST;
            faddr_q <= 7'h00;
        end else if (apb_wr && paddr_i == OFF_INSTR) begin
            instr_q <= iw;
        end else if (apb_wr && paddr_i == OFF_FADDR) begin
            faddr_q <= pwdata_i[6:0];
        end
    end

    assign fdata_rd = (faddr_q == PORT_FADDR) ? pin_sync_q : file_q[faddr_q];
    always_comb begin
        case (paddr_i)
            OFF_INSTR: rd_data = {18'h00000, instr_q};
            OFF_ACC: rd_data = {24'h000000, acc_q};
            OFF_STATUS: rd_data = {28'h0000000, skip_q, zero_q, nibble_carry_q, carry_q};
            OFF_FADDR: rd_data = {25'h0000000, faddr_q};
            OFF_FDATA: rd_data = {24'h000000, fdata_rd};
            default: rd_data = 32'h00000000;
        endcase
    end

    // one wait state keeps all bus outputs registered
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (psel_i && penable_i && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !addr_ok;
            prdata_q <= pwrite_i ? 32'h00000000 : rd_data;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign port_latch_o = port_latch_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence instr_wr_s;
        apb_wr && paddr_i == OFF_INSTR;
    endsequence
    sequence skip_armed_s;
        skip_q ##0 instr_wr_s;
    endsequence

    a_add_imm_result: assert property (exec && kind == OP_ADD_IMM |=>
        {carry_q, acc_q} == 9'($past({1'b0, acc_q}) + $past({1'b0, lit})))
        else $error("add immediate result or carry wrong");
    a_add_reg_dest: assert property (exec && kind == OP_ADD_REG && dest_reg |=>
        $stable(acc_q) && zero_q == (8'($past(acc_q) + $past(operand)) == 8'h00))
        else $error("add to register touched acc or zero wrong");
    a_and_imm_flags: assert property (exec && kind == OP_AND_IMM |=>
        acc_q == ($past(acc_q) & $past(lit)) && $stable(carry_q) && $stable(nibble_carry_q))
        else $error("and immediate result or flags wrong");
    a_and_reg_acc: assert property (exec && kind == OP_AND_REG && !dest_reg |=>
        acc_q == ($past(acc_q) & $past(operand)) && $stable(carry_q))
        else $error("and register to acc wrong");
    a_bit_clear_op: assert property (exec && kind == OP_BIT_CLR && f_addr != PORT_FADDR |=>
        file_q[$past(f_addr)] == ($past(operand) & ~$past(bit_mask)) && $stable(zero_q))
        else $error("bit clear result wrong");
    a_bit_set_op: assert property (exec && kind == OP_BIT_SET && f_addr != PORT_FADDR |=>
        file_q[$past(f_addr)] == ($past(operand) | $past(bit_mask)) && $stable(carry_q))
        else $error("bit set result wrong");
    a_skip_one_arm: assert property (exec && kind == OP_SKIP_ONE |=>
        skip_q == $past(operand[bit_idx]))
        else $error("skip on one armed wrongly");
    a_skip_one_nop: assert property (skip_armed_s |=>
        !skip_q && $stable(acc_q) && $stable(zero_q))
        else $error("skip on one did not discard next instruction");
    a_skip_zero_arm: assert property (exec && kind == OP_SKIP_ZERO |=>
        skip_q == !$past(operand[bit_idx]))
        else $error("skip on zero armed wrongly");
    a_skip_clears: assert property (skip_armed_s |=> !skip_q && $stable(port_latch_q) && $stable(carry_q))
        else $error("pending skip not consumed");
    a_port_pins_rmw: assert property (exec && kind == OP_AND_REG && dest_reg && f_addr == PORT_FADDR |=>
        port_latch_q == ($past(acc_q) & $past(pin_sync_q)))
        else $error("port write-back did not use pin levels");
    a_field_bit_idx: assert property (exec && kind == OP_BIT_SET && f_addr != PORT_FADDR |=>
        file_q[$past(iw[6:0])][$past(iw[9:7])] == 1'b1)
        else $error("bit index or address field misdecoded");
    a_bus_wait_one: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
        else $error("bus answer not a single-cycle pready");
endmodule : alu_literal_and_bit_ops

/* File: sim/testbench.sv */
// self-checking bench for the literal and bit-op datapath, driven over apb
`timescale 1ns/1ps
module testbench;
    import alu_ops_pkg::*;
    logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i;
    logic [7:0] paddr_i, port_pins_i, port_latch_o;
    logic [31:0] pwdata_i, prdata_o, rd, v;
    logic pready_o, pslverr_o, err;
    logic [7:0] acc_m, latch_m, pins_m;
    logic [7:0] file_m [128];
    logic c_m, dc_m, z_m, skip_m;
    int fails = 0;
    int check_count = 0;
    integer seed = 32'h8798;

    alu_literal_and_bit_ops #(.FILE_DEPTH(128)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .port_pins_i(port_pins_i), .port_latch_o(port_latch_o));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // master holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            give_verdict();
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask : wreg

    function automatic logic [7:0] rdf(input logic [6:0] f);
        return (f == PORT_FADDR) ? pins_m : file_m[f];
    endfunction : rdf

    function automatic void wrf(input logic [6:0] f, input logic [7:0] d);
        if (f == PORT_FADDR) latch_m = d;
        else file_m[f] = d;
    endfunction : wrf

    function automatic logic [7:0] addf(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, b};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        c_m = s[8];
        dc_m = n[4];
        z_m = (s[7:0] == 8'h00);
        return s[7:0];
    endfunction : addf

    // reference behaviour; port operands come from the pins, not the latch
    function automatic void model(input logic [13:0] w);
        logic [7:0] op, res;
        op = rdf(w[6:0]);
        res = op;
        if (skip_m) begin
            skip_m = 1'b0;
            return;
        end
        casez (w[13:8])
            6'b11111?: acc_m = addf(acc_m, w[7:0]);
            6'b111001: begin
                acc_m = acc_m & w[7:0];
                z_m = (acc_m == 8'h00);
            end
            6'b000111, 6'b000101: begin
                res = w[9] ? addf(acc_m, op) : (acc_m & op);
                if (!w[9]) z_m = (res == 8'h00);
                if (w[7]) wrf(w[6:0], res);
                else acc_m = res;
            end
            6'b0100??, 6'b0101??: begin
                res[w[9:7]] = w[10];
                wrf(w[6:0], res);
            end
            6'b0110??, 6'b0111??: skip_m = (op[w[9:7]] == w[10]);
            default: ;
        endcase
    endfunction : model

    function automatic logic [13:0] rnd_instr();
        logic [7:0] k;
        logic [6:0] f;
        logic [2:0] b;
        int r;
        k = $random(seed);
        r = $unsigned($random(seed)) % 17;
        f = (r == 16) ? 7'h7F : r[6:0];
        b = $random(seed);
        case ($unsigned($random(seed)) % 8)
            0: return {5'b11111, k[0], k};
            1: return {6'b111001, k};
            2: return {6'b000111, b[0], f};
            3: return {6'b000101, b[0], f};
            4: return {4'b0100, b, f};
            5: return {4'b0101, b, f};
            6: return {4'b0110, b, f};
            default: return {4'b0111, b, f};
        endcase
    endfunction : rnd_instr

    task automatic run(input logic [13:0] w);
        wreg(OFF_INSTR, {18'h0, w});
        model(w);
        apb(1'b0, OFF_ACC, 32'h0, rd, err);
        check("acc", rd, {24'h0, acc_m});
        check("slverr", {31'h0, err}, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0, rd, err);
        check("status", rd, {28'h0, skip_m, z_m, dc_m, c_m});
        check("latch", {24'h0, port_latch_o}, {24'h0, latch_m});
    endtask : run

    task automatic setf(input logic [6:0] f, input logic [7:0] d);
        wreg(OFF_FADDR, {25'h0, f});
        wreg(OFF_FDATA, {24'h0, d});
        wrf(f, d);
    endtask : setf

    task automatic dump(input bit init);
        logic [6:0] f;
        for (int j = 0; j < 17; j++) begin
            f = (j == 16) ? 7'h7F : j[6:0];
            if (init) setf(f, $random(seed));
            wreg(OFF_FADDR, {25'h0, f});
            apb(1'b0, OFF_FDATA, 32'h0, rd, err);
            check("file", rd, {24'h0, rdf(f)});
        end
    endtask : dump

    // pins pass a two-stage synchroniser, so settle before use
    task automatic setpins(input logic [7:0] p);
        @(posedge clk_i);
        port_pins_i <= p;
        pins_m = p;
        repeat (4) @(posedge clk_i);
    endtask : setpins

    initial begin
        sys_rst_i = 1'b1;
        {psel_i, penable_i, pwrite_i} = 3'h0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        port_pins_i = 8'h00;
        {acc_m, latch_m, pins_m} = 24'h0;
        {c_m, dc_m, z_m, skip_m} = 4'h0;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        run({6'b111001, 8'hFF});
        dump(1'b1);
        wreg(OFF_ACC, 32'h01);
        acc_m = 8'h01;
        run({6'b111110, 8'hFF});
        run({6'b111001, 8'h00});
        run({4'b0101, 3'd7, 7'd3});
        run({4'b0111, 3'd7, 7'd3});
        run({6'b111110, 8'h11});
        run({4'b0110, 3'd7, 7'd3});
        run({4'b0100, 3'd7, 7'd3});
        run({4'b0110, 3'd7, 7'd3});
        run({4'b0101, 3'd0, 7'h7F});
        setpins(8'hA5);
        setf(7'd5, 8'hFF);
        run({4'b0100, 3'd0, 7'd5});
        apb(1'b1, 8'h14, 32'hFFFFFFFF, rd, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h14, 32'h0, rd, err);
        check("unmapped data", {err, rd[30:0]}, 32'h80000000);
        for (int i = 0; i < 240; i++) begin
            if (i % 40 == 0) setpins($random(seed));
            if (i % 30 == 0) dump(1'b0);
            v = $random(seed);
            if (!skip_m && v[7:6] == 2'b00) begin
                wreg(OFF_STATUS, {29'h0, v[2:0]});
                {z_m, dc_m, c_m} = v[2:0];
            end
            run(rnd_instr());
        end
        dump(1'b0);
        give_verdict();
    end

    // no run needs anywhere near this many cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        give_verdict();
    end
endmodule : testbench
